// [logic/wbm_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module wbm_regs (
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port from the serial frame engine
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [6:0] rd_addr,
  output logic [7:0]      rd_data,
  output logic            spi_fail,
  // Device mode field of the mode control register
  input  wire logic [1:0] dev_mode,
  // Hardware updates of rwh fields
  input  wire logic       hw_wd_wr,
  input  wire logic [7:0] hw_wd_data,
  input  wire logic       hw_bus_wr,
  input  wire logic [7:0] hw_bus1_data,
  input  wire logic [7:0] hw_bus2_data,
  // Configuration to the watchdog
  output logic            wdog_stop_disable,
  output logic            wdog_window_select,
  output logic            wdog_start_on_bus_wake,
  output logic            wdog_max3_reset,
  output logic [2:0]      wdog_period_select,
  output logic            wdog_period_reserved,
  // Configuration to the transceivers
  output logic            lin_flash_mode,
  output logic            lin_low_slope_select,
  output logic            lin_tx_timeout_enable,
  output logic [1:0]      can_mode_eff,
  output logic [1:0]      lin_channel_1_mode,
  output logic [1:0]      lin_channel_2_mode,
  output logic [1:0]      lin_channel_3_mode,
  output logic [1:0]      lin_channel_4_mode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] wdog_cfg;
    logic [7:0] xcvr_primary;
    logic [7:0] lin_aux;
    logic [7:0] rd_data;
    logic       fail;
    logic [1:0] can_eff;
    logic [1:0] lin_channel_1_mode_eff;
    logic [1:0] lin_channel_2_mode_eff;
    logic [1:0] lin_channel_3_mode_eff;
    logic [1:0] lin_channel_4_mode_eff;
  } wbm_state_type;

  wbm_state_type st_q;
  wbm_state_type st_d;

  wbm_wr_if wr ();
  assign wr.wr_en = wr_en;
  assign wr.addr  = wr_addr;
  assign wr.data  = wr_data;

  logic       parity_ok;
  logic [1:0] can_e;
  logic [1:0] lin_channel_1_mode_e;
  logic [1:0] lin_channel_2_mode_e;
  logic [1:0] lin_channel_3_mode_e;
  logic [1:0] lin_channel_4_mode_e;

  wbm_parity u_parity (
    .data    (wr.data),
    .even_ok (parity_ok)
  );

  // ----------------------------------------------------------------
  // Demotion: stored fields feed it, never its outputs back
  // ----------------------------------------------------------------
  wbm_demote u_dem_can (
    .stored    (st_q.xcvr_primary[wbm_pkg::BP_CAN_LSB +: 2]),
    .dev_mode  (dev_mode),
    .effective (can_e)
  );
  wbm_demote u_dem_lin_channel_1_mode (
    .stored    (st_q.xcvr_primary[wbm_pkg::BP_LIN_CHANNEL_1_MODE_LSB +: 2]),
    .dev_mode  (dev_mode),
    .effective (lin_channel_1_mode_e)
  );
  wbm_demote u_dem_lin_channel_2_mode (
    .stored    (st_q.lin_aux[wbm_pkg::AUX_LIN_CHANNEL_2_MODE_LSB +: 2]),
    .dev_mode  (dev_mode),
    .effective (lin_channel_2_mode_e)
  );
  wbm_demote u_dem_lin_channel_3_mode (
    .stored    (st_q.lin_aux[wbm_pkg::AUX_LIN_CHANNEL_3_MODE_LSB +: 2]),
    .dev_mode  (dev_mode),
    .effective (lin_channel_3_mode_e)
  );
  wbm_demote u_dem_lin_channel_4_mode (
    .stored    (st_q.lin_aux[wbm_pkg::AUX_LIN_CHANNEL_4_MODE_LSB +: 2]),
    .dev_mode  (dev_mode),
    .effective (lin_channel_4_mode_e)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.fail = 1'b0;
    // Hardware updates first; a host write in the same cycle wins, except a watchdog write that fails parity
    // Hardware touches only its masked bits; in lin_aux that mask covers every stored bit
    if (hw_wd_wr) begin
      st_d.wdog_cfg = (st_q.wdog_cfg & ~wbm_pkg::HW_MASK_WDOG)
                      | (hw_wd_data & wbm_pkg::HW_MASK_WDOG);
    end
    if (hw_bus_wr) begin
      st_d.xcvr_primary = (st_q.xcvr_primary & ~wbm_pkg::HW_MASK_XCVR_PRI)
                          | (hw_bus1_data & wbm_pkg::HW_MASK_XCVR_PRI);
      st_d.lin_aux      = (st_q.lin_aux & ~wbm_pkg::HW_MASK_LIN_AUX)
                          | (hw_bus2_data & wbm_pkg::HW_MASK_LIN_AUX);
    end
    if (wr.wr_en) begin
      case (wr.addr)
        wbm_pkg::ADDR_WDOG_CONFIG: begin
          if (parity_ok) begin
            st_d.wdog_cfg = wr.data & wbm_pkg::MASK_WDOG_READ;
          end else begin
            st_d.fail = 1'b1;
          end
        end
        wbm_pkg::ADDR_XCVR_PRIMARY: begin
          st_d.xcvr_primary = wr.data & wbm_pkg::MASK_XCVR_PRIMARY;
        end
        wbm_pkg::ADDR_LIN_AUX: begin
          st_d.lin_aux = wr.data & wbm_pkg::MASK_LIN_AUX;
        end
        default: begin
          st_d.fail = st_d.fail;
        end
      endcase
    end
    case (rd_addr)
      wbm_pkg::ADDR_WDOG_CONFIG:  st_d.rd_data = st_d.wdog_cfg & wbm_pkg::MASK_WDOG_READ;
      wbm_pkg::ADDR_XCVR_PRIMARY: st_d.rd_data = st_d.xcvr_primary;
      wbm_pkg::ADDR_LIN_AUX:      st_d.rd_data = st_d.lin_aux;
      default:                    st_d.rd_data = 8'h00;
    endcase
    st_d.can_eff  = can_e;
    st_d.lin_channel_1_mode_eff = lin_channel_1_mode_e;
    st_d.lin_channel_2_mode_eff = lin_channel_2_mode_e;
    st_d.lin_channel_3_mode_eff = lin_channel_3_mode_e;
    st_d.lin_channel_4_mode_eff = lin_channel_4_mode_e;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q              <= '0;
      st_q.wdog_cfg     <= wbm_pkg::RST_WDOG_CONFIG;
      st_q.xcvr_primary <= wbm_pkg::RST_XCVR_PRIMARY;
      st_q.lin_aux      <= wbm_pkg::RST_LIN_AUX;
      st_q.rd_data      <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from the registered state
  // ----------------------------------------------------------------
  assign rd_data                = st_q.rd_data;
  assign spi_fail               = st_q.fail;
  assign wdog_stop_disable      = st_q.wdog_cfg[wbm_pkg::WD_STOP_DIS_BIT];
  assign wdog_window_select     = st_q.wdog_cfg[wbm_pkg::WD_WINDOW_BIT];
  assign wdog_start_on_bus_wake = st_q.wdog_cfg[wbm_pkg::WD_BUS_WAKE_BIT];
  assign wdog_max3_reset        = st_q.wdog_cfg[wbm_pkg::WD_MAX3_BIT];
  assign wdog_period_select     = st_q.wdog_cfg[wbm_pkg::WD_PERIOD_LSB +: 3];
  assign wdog_period_reserved   = (st_q.wdog_cfg[wbm_pkg::WD_PERIOD_LSB +: 3]
                                   == wbm_pkg::PERIOD_RESERVED);
  assign lin_flash_mode         = st_q.xcvr_primary[wbm_pkg::BP_FLASH_BIT];
  assign lin_low_slope_select   = st_q.xcvr_primary[wbm_pkg::BP_LOW_SLOPE_BIT];
  assign lin_tx_timeout_enable  = st_q.xcvr_primary[wbm_pkg::BP_TX_TO_BIT];
  assign can_mode_eff           = st_q.can_eff;
  assign lin_channel_1_mode     = st_q.lin_channel_1_mode_eff;
  assign lin_channel_2_mode     = st_q.lin_channel_2_mode_eff;
  assign lin_channel_3_mode     = st_q.lin_channel_3_mode_eff;
  assign lin_channel_4_mode     = st_q.lin_channel_4_mode_eff;
endmodule
`default_nettype wire

// [inc/wbm_pkg.sv]
package wbm_pkg;
  // ----------------------------------------------------------------
  // Register map (7-bit register addresses)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_WDOG_CONFIG   = 7'h03;
  localparam logic [6:0] ADDR_XCVR_PRIMARY  = 7'h04;
  localparam logic [6:0] ADDR_LIN_AUX       = 7'h05;
  localparam logic [6:0] ADDR_MODE_CTRL     = 7'h01;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_WDOG_CONFIG    = 8'h14;
  localparam logic [7:0] RST_XCVR_PRIMARY   = 8'h20;
  localparam logic [7:0] RST_LIN_AUX        = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WD_PARITY_BIT   = 7;
  localparam int WD_STOP_DIS_BIT = 6;
  localparam int WD_WINDOW_BIT   = 5;
  localparam int WD_BUS_WAKE_BIT = 4;
  localparam int WD_MAX3_BIT     = 3;
  localparam int WD_PERIOD_LSB   = 0;
  localparam int BP_FLASH_BIT    = 7;
  localparam int BP_LOW_SLOPE_BIT = 6;
  localparam int BP_TX_TO_BIT    = 5;
  localparam int BP_LIN_CHANNEL_1_MODE_LSB     = 3;
  localparam int BP_CAN_LSB      = 0;
  localparam int AUX_LIN_CHANNEL_2_MODE_LSB    = 0;
  localparam int AUX_LIN_CHANNEL_3_MODE_LSB    = 3;
  localparam int AUX_LIN_CHANNEL_4_MODE_LSB    = 6;
  localparam int MODE_LSB        = 6;

  localparam logic [7:0] MASK_WDOG_READ     = 8'h7F;
  localparam logic [7:0] MASK_XCVR_PRIMARY  = 8'hFB;
  localparam logic [7:0] MASK_LIN_AUX       = 8'hDB;

  // Bits that hardware may update; plain rw bits stay host-owned
  localparam logic [7:0] HW_MASK_WDOG       = 8'h57;
  localparam logic [7:0] HW_MASK_XCVR_PRI   = 8'h1B;
  localparam logic [7:0] HW_MASK_LIN_AUX    = 8'hDB;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    XCVR_OFF     = 2'h0,
    XCVR_WAKE    = 2'h1,
    XCVR_RX_ONLY = 2'h2,
    XCVR_NORMAL  = 2'h3
  } wbm_xcvr_type;

  typedef enum logic [1:0] {
    DEV_NORMAL = 2'h0,
    DEV_SLEEP  = 2'h1,
    DEV_STOP   = 2'h2,
    DEV_RESET  = 2'h3
  } wbm_devmode_type;

  // Period times in ms for codes 000..110; 111 reserved
  localparam int PERIOD_MS_0 = 10;
  localparam int PERIOD_MS_1 = 20;
  localparam int PERIOD_MS_2 = 50;
  localparam int PERIOD_MS_3 = 100;
  localparam int PERIOD_MS_4 = 200;
  localparam int PERIOD_MS_5 = 500;
  localparam int PERIOD_MS_6 = 1000;
  localparam logic [2:0] PERIOD_RESERVED = 3'h7;
endpackage

// [inc/wbm_wr_if.sv]
`timescale 1ns/1ns
`default_nettype none
// Write request handed from the top to the register slice
interface wbm_wr_if;
  logic       wr_en;
  logic [6:0] addr;
  logic [7:0] data;
  modport src (output wr_en, output addr, output data);
  modport dst (input wr_en, input addr, input data);
endinterface
`default_nettype wire

// [logic/wbm_parity.sv]
`timescale 1ns/1ns
`default_nettype none
// Even-parity checker for a watchdog configuration write
module wbm_parity (
  input  wire logic [7:0] data,
  output logic            even_ok
);
  assign even_ok = ~(^data);
endmodule
`default_nettype wire

// [logic/wbm_demote.sv]
`timescale 1ns/1ns
`default_nettype none
// Maps a stored transceiver mode to what the transceiver runs in
module wbm_demote (
  input  wire logic [1:0] stored,
  input  wire logic [1:0] dev_mode,
  output logic [1:0]      effective
);
  logic low_power;
  assign low_power = (dev_mode == wbm_pkg::DEV_STOP) || (dev_mode == wbm_pkg::DEV_SLEEP);
  always_comb begin
    effective = stored;
    if (low_power && stored == wbm_pkg::XCVR_NORMAL) begin
      effective = wbm_pkg::XCVR_WAKE;
    end
  end
endmodule
`default_nettype wire

// [bench/wbm_regs_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module wbm_regs_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       spi_fail,
  input wire logic [1:0] dev_mode,
  input wire logic       hw_wd_wr,
  input wire logic [2:0] wdog_period_select,
  input wire logic       wdog_window_select,
  input wire logic       wdog_max3_reset,
  input wire logic       lin_low_slope_select,
  input wire logic       lin_tx_timeout_enable,
  input wire logic [1:0] can_mode_eff,
  input wire logic [1:0] lin_channel_4_mode
);
  logic wd_odd;
  logic wd_good;
  logic low_pwr;
  assign wd_odd  = wr_en && (wr_addr == wbm_pkg::ADDR_WDOG_CONFIG) && (^wr_data);
  assign wd_good = wr_en && (wr_addr == wbm_pkg::ADDR_WDOG_CONFIG) && !(^wr_data);
  assign low_pwr = (dev_mode == 2'h1) || (dev_mode == 2'h2);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  parity_fail_a: assert property (wd_odd |=> spi_fail)
    else $error("odd watchdog write gave no fail pulse");
  fail_cause_a: assert property (spi_fail |-> $past(wd_odd))
    else $error("fail pulse without odd watchdog write");
  reject_keep_a: assert property (wd_odd && !hw_wd_wr |=>
    $stable(wdog_period_select) && $stable(wdog_window_select) && $stable(wdog_max3_reset))
    else $error("rejected write changed watchdog fields");
  wd_fields_a: assert property (wd_good |=> wdog_period_select == $past(wr_data[2:0])
    && wdog_window_select == $past(wr_data[5])) else $error("watchdog fields not taken");
  max3_take_a: assert property (wd_good |=> wdog_max3_reset == $past(wr_data[3]))
    else $error("reset limit bit not taken");
  parity_zero_a: assert property ($past(rd_addr) == 7'h03 |-> !rd_data[7])
    else $error("parity bit read nonzero");
  reserved_pri_a: assert property ($past(rd_addr) == 7'h04 |-> !rd_data[2])
    else $error("reserved bit of primary register read nonzero");
  reserved_aux_a: assert property ($past(rd_addr) == 7'h05 |-> !rd_data[5] && !rd_data[2])
    else $error("reserved bits of aux register read nonzero");
  slope_take_a: assert property (wr_en && wr_addr == 7'h04 |=>
    lin_low_slope_select == $past(wr_data[6]) && lin_tx_timeout_enable == $past(wr_data[5]))
    else $error("slope or timeout bit not taken");
  no_normal_a: assert property (low_pwr |=> can_mode_eff != 2'h3 && lin_channel_4_mode != 2'h3)
    else $error("normal mode kept in low power");
  cover property (spi_fail);
  cover property (low_pwr && can_mode_eff == 2'h1);
  cover property (wdog_period_select == 3'h7);
endmodule
bind wbm_regs wbm_regs_asserts chk (.clk, .rst, .wr_en, .wr_addr, .wr_data, .rd_addr,
  .rd_data, .spi_fail, .dev_mode, .hw_wd_wr, .wdog_period_select, .wdog_window_select,
  .wdog_max3_reset, .lin_low_slope_select, .lin_tx_timeout_enable, .can_mode_eff,
  .lin_channel_4_mode);
`default_nettype wire

// [bench/wbm_host.sv]
`timescale 1ns/1ns
`default_nettype none
// Host side of the register port, one request at a time
module wbm_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output var  logic       wr_en,
  output var  logic [6:0] wr_addr,
  output var  logic [7:0] wr_data,
  output var  logic [6:0] rd_addr
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 7'h00;
    wr_data = 8'h00;
    rd_addr = 7'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en   <= 1'b0;
    // Released data must not keep showing the last byte
    wr_data <= ~d;
  endtask
  task automatic wd_wr(input logic [6:0] low);
    wr(7'h03, {^low, low});
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// [bench/wbm_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module wbm_regs_tb;
  logic       clk;
  logic       rst;
  logic [1:0] dev_mode;
  logic [6:0] low;
  logic       hw_wd_wr;
  logic [7:0] hw_wd_data;
  logic       hw_bus_wr;
  logic [7:0] hw_bus1_data;
  logic [7:0] hw_bus2_data;
  wire        wdog_stop_disable;
  wire        lin_flash_mode;
  wire        wr_en;
  wire  [6:0] wr_addr;
  wire  [7:0] wr_data;
  wire  [6:0] rd_addr;
  wire  [7:0] rd_data;
  wire        spi_fail;
  wire        wdog_period_reserved;
  wire  [1:0] can_mode_eff;
  wire  [1:0] lin_channel_1_mode;
  wire  [1:0] lin_channel_4_mode;
  int         failures = 0;
  int         samples_checked = 0;
  wbm_host host (.clk, .rd_data, .wr_en, .wr_addr, .wr_data, .rd_addr);
  wbm_regs uut (.clk, .rst, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data, .spi_fail,
    .dev_mode, .hw_wd_wr, .hw_wd_data, .hw_bus_wr,
    .hw_bus1_data, .hw_bus2_data, .wdog_stop_disable,
    .wdog_window_select(), .wdog_start_on_bus_wake(), .wdog_max3_reset(),
    .wdog_period_select(), .wdog_period_reserved, .lin_flash_mode,
    .lin_low_slope_select(), .lin_tx_timeout_enable(), .can_mode_eff, .lin_channel_1_mode,
    .lin_channel_2_mode(), .lin_channel_3_mode(), .lin_channel_4_mode);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic go(input logic [1:0] m);
    @(posedge clk);
    dev_mode <= m;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 20000);
    failures++;
    test_done;
  end
  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    dev_mode = 2'h0;
    low = 7'h00;
    hw_wd_wr = 1'b0;
    hw_wd_data = 8'h00;
    hw_bus_wr = 1'b0;
    hw_bus1_data = 8'h00;
    hw_bus2_data = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(7'h03, 8'h14);
    rchk(7'h04, 8'h20);
    rchk(7'h05, 8'h00);
    for (int i = 0; i < 8; i++) begin
      low = {i[3:0], i[2:0]};
      host.wd_wr(low);
      @(negedge clk);
      chk({7'h00, spi_fail}, 8'h00);
      chk({7'h00, wdog_period_reserved}, {7'h00, i == 7});
      rchk(7'h03, {1'b0, low});
    end
    host.wr(7'h03, 8'h01);
    @(negedge clk);
    chk({7'h00, spi_fail}, 8'h01);
    rchk(7'h03, 8'h3F);
    @(posedge clk);
    hw_wd_wr   <= 1'b1;
    hw_wd_data <= 8'hC0;
    @(posedge clk);
    hw_wd_wr   <= 1'b0;
    rchk(7'h03, 8'h68);
    chk({7'h00, wdog_stop_disable}, 8'h01);
    host.wr(7'h7F, 8'hA5);
    rchk(7'h7F, 8'h00);
    host.wr(7'h04, 8'hFF);
    rchk(7'h04, 8'hFB);
    chk({7'h00, lin_flash_mode}, 8'h01);
    host.wr(7'h05, 8'hFF);
    rchk(7'h05, 8'hDB);
    for (int m = 2; m >= 0; m -= 2) begin
      go(m[1:0]);
      chk({6'h00, can_mode_eff}, (m == 0) ? 8'h03 : 8'h01);
      chk({6'h00, lin_channel_4_mode}, (m == 0) ? 8'h03 : 8'h01);
      rchk(7'h04, 8'hFB);
    end
    host.wr(7'h04, 8'hF9);
    go(2'h1);
    chk({6'h00, lin_channel_1_mode}, 8'h01);
    chk({6'h00, can_mode_eff}, 8'h01);
    go(2'h0);
    host.wr(7'h04, 8'h12);
    go(2'h2);
    chk({6'h00, can_mode_eff}, 8'h02);
    chk({6'h00, lin_channel_1_mode}, 8'h02);
    @(posedge clk);
    hw_bus_wr    <= 1'b1;
    hw_bus1_data <= 8'hFF;
    hw_bus2_data <= 8'h00;
    @(posedge clk);
    hw_bus_wr    <= 1'b0;
    rchk(7'h04, 8'h1B);
    rchk(7'h05, 8'h00);
    test_done;
  end
endmodule
`default_nettype wire
